// [pkg/vad_pkg.sv]
`default_nettype none
package vad_pkg;

  // ==========================================================
  // Instruction word layout
  localparam logic [6:0] VAD_MAJOR_OPCODE = 7'h57;
  localparam int VAD_OPSEL_HI = 31;
  localparam int VAD_OPSEL_LO = 26;
  localparam int VAD_MASK_BIT = 25;
  localparam int VAD_SRC2_HI = 24;
  localparam int VAD_SRC2_LO = 20;
  localparam int VAD_SRC1_HI = 19;
  localparam int VAD_SRC1_LO = 15;
  localparam int VAD_CAT_HI = 14;
  localparam int VAD_CAT_LO = 12;
  localparam int VAD_DEST_HI = 11;
  localparam int VAD_DEST_LO = 7;
  localparam int VAD_CFG_SEL_HI = 31;
  localparam int VAD_CFG_SEL_LO = 30;
  localparam int VAD_CFG_IMM_HI = 30;
  localparam int VAD_CFG_IMM_LO = 20;

  // ==========================================================
  // Element widths, rounding modes, canonical quiet NaNs
  localparam int VAD_ELEN = 64;
  localparam logic [2:0] VAD_FRM_MAX_VALID = 3'h4;
  localparam logic [63:0] VAD_NAN_H = 64'h0000_0000_0000_7e00;
  localparam logic [63:0] VAD_NAN_S = 64'h0000_0000_7fc0_0000;
  localparam logic [63:0] VAD_NAN_D = 64'h7ff8_0000_0000_0000;

  typedef enum logic [2:0] {
    VAD_INT_VEC_VEC_CATEGORY = 3'h0,
    VAD_FLOAT_VEC_VEC_CATEGORY = 3'h1,
    VAD_MASKMUL_VEC_VEC_CATEGORY = 3'h2,
    VAD_INT_VEC_IMM_CATEGORY = 3'h3,
    VAD_INT_VEC_SCALAR_CATEGORY = 3'h4,
    VAD_FLOAT_VEC_SCALAR_CATEGORY = 3'h5,
    VAD_MASKMUL_VEC_SCALAR_CATEGORY = 3'h6,
    VAD_VECTOR_CONFIG_CATEGORY = 3'h7
  } vad_cat_e;

  // Element width code: 8 << code bits
  typedef enum logic [1:0] {
    VAD_SEW_8 = 2'h0,
    VAD_SEW_16 = 2'h1,
    VAD_SEW_32 = 2'h2,
    VAD_SEW_64 = 2'h3
  } vad_sew_e;

  typedef enum logic [1:0] {
    VAD_SRC_NONE = 2'h0,
    VAD_SRC_IMM = 2'h1,
    VAD_SRC_XREG = 2'h2,
    VAD_SRC_FREG = 2'h3
  } vad_src_e;

  // ==========================================================
  // Register map (AHB-Lite, byte offsets)
  localparam int VAD_AW = 8;
  localparam logic [7:0] VAD_CTRL_OFS = 8'h00;
  localparam logic [7:0] VAD_STAT_OFS = 8'h04;
  localparam logic [7:0] VAD_LAST_OFS = 8'h08;
  localparam int VAD_CTRL_SEW_LO = 0;
  localparam int VAD_CTRL_FRM_LO = 2;
  localparam int VAD_CTRL_FINT_BIT = 5;
  localparam int VAD_CTRL_EN_BIT = 6;
  localparam logic [1:0] VAD_CTRL_SEW_RST = 2'h0;
  localparam logic [2:0] VAD_CTRL_FRM_RST = 3'h0;

  // ==========================================================
  // Decoded result handed to the execution lanes
  typedef struct packed {
    logic valid;
    logic illegal;
    logic [5:0] operation_select_field;
    logic mask_enable_bit;
    logic [4:0] second_vector_source;
    logic [4:0] first_vector_source;
    logic [4:0] vector_destination;
    vad_cat_e category;
    logic read_src2_vec;
    logic read_src1_vec;
    vad_src_e scalar_src;
    logic dest_we;
    logic op_signed;
    logic [2:0] round_mode;
    logic cfg_second_reg;
    logic [10:0] cfg_imm;
    logic [VAD_ELEN-1:0] scalar_operand;
  } vad_dec_s;

endpackage : vad_pkg
`default_nettype wire

// [core/vad_scalar_fmt.sv]
`default_nettype none
module vad_scalar_fmt #(
  parameter int INTEGER_REGISTER_WIDTH = 64,
  parameter int FLOAT_REGISTER_WIDTH = 64
) (
  // Selection
  input wire vad_pkg::vad_sew_e selected_element_width,
  input wire vad_pkg::vad_src_e src,
  input wire logic uimm,
  // Raw sources
  input wire logic [4:0] imm,
  input wire logic [INTEGER_REGISTER_WIDTH-1:0] xreg,
  input wire logic [FLOAT_REGISTER_WIDTH-1:0] freg,
  // Formatted element, zero above the element width
  output logic [vad_pkg::VAD_ELEN-1:0] operand
);
  import vad_pkg::*;

  logic [VAD_ELEN-1:0] x_ext;
  logic [VAD_ELEN-1:0] f_low;
  logic [VAD_ELEN-1:0] width_mask;
  logic [VAD_ELEN-1:0] nan_val;
  logic [7:0] sew_bits;
  logic box_ok;

  // ==========================================================
  // Per-bit widening of the register images
  for (genvar g = 0; g < VAD_ELEN; g++) begin : g_ext
    if (g < INTEGER_REGISTER_WIDTH) begin : g_xin
      assign x_ext[g] = xreg[g];
    end else begin : g_xsign
      assign x_ext[g] = xreg[INTEGER_REGISTER_WIDTH-1]; // [RULE9]
    end
    if (g < FLOAT_REGISTER_WIDTH) begin : g_fin
      assign f_low[g] = freg[g];
    end else begin : g_fzero
      assign f_low[g] = 1'b0;
    end
    assign width_mask[g] = (8'(g) < sew_bits);
  end

  assign sew_bits = 8'(8) << selected_element_width;

  // Boxing holds when every bit above the element is one
  always_comb begin
    box_ok = 1'b1;
    for (int i = 0; i < FLOAT_REGISTER_WIDTH; i++) begin
      if ((i >= int'(sew_bits)) && !freg[i]) begin
        box_ok = 1'b0; // [RULE10]
      end
    end
  end

  always_comb begin
    case (selected_element_width)
      VAD_SEW_16: nan_val = VAD_NAN_H;
      VAD_SEW_32: nan_val = VAD_NAN_S;
      VAD_SEW_64: nan_val = VAD_NAN_D;
      default: nan_val = '0;
    endcase
  end

  always_comb begin
    case (src)
      VAD_SRC_IMM: begin
        if (uimm) begin
          operand = {{(VAD_ELEN-5){1'b0}}, imm} & width_mask; // [RULE8]
        end else begin
          operand = {{(VAD_ELEN-5){imm[4]}}, imm} & width_mask; // [RULE7]
        end
      end
      VAD_SRC_XREG: operand = x_ext & width_mask; // [RULE9]
      VAD_SRC_FREG: operand = box_ok ? (f_low & width_mask) : nan_val; // [RULE10]
      default: operand = '0;
    endcase
  end

endmodule : vad_scalar_fmt
`default_nettype wire

// [core/vad_decode.sv]
// Summary of operation
// RULE1 - Major opcode 1010111 marks vector arithmetic
// RULE2 - Split word into select, mask, sources, destination
// RULE3 - Category field bits 14:12 picks operand form
// RULE4 - Configuration: integer source plus register or immediate
// RULE5 - Vector-vector reads both vector source groups
// RULE6 - Vector-scalar: vector from second source field
// RULE7 - Immediate sign-extended to element width
// RULE8 - Unsigned-immediate operations zero-extend instead
// RULE9 - Integer scalar truncated or sign-extended
// RULE10 - Float scalar boxing checked, else canonical NaN
// RULE11 - Unsupported float element width is reserved
// RULE12 - Float-in-integer mode uses integer scalar rules
// RULE13 - Mask enable bit 25 controls element masking
// RULE14 - Operation code picks signed or unsigned
// RULE15 - Float ops round by dynamic mode field
// RULE16 - Invalid rounding mode reserved for any float op
// RULE17 - Invalid rounding mode may always raise exception
// RULE18 - Reserved encodings flag illegal, block writes
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`default_nettype none
module vad_decode #(
  parameter int INTEGER_REGISTER_WIDTH = 64,
  parameter int FLOAT_REGISTER_WIDTH = 64,
  // Bit n set: element width code n is a supported float format
  parameter logic [3:0] FP_SEW_MASK = 4'he,
  // Bit n set: operation select n takes an unsigned immediate
  parameter logic [63:0] UIMM_OPS = 64'h0,
  // Bit n set: operation select n uses signed arithmetic
  parameter logic [63:0] SIGNED_OPS = 64'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Issue side
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [INTEGER_REGISTER_WIDTH-1:0] xreg_data,
  input wire logic [FLOAT_REGISTER_WIDTH-1:0] freg_data,
  // Execution side
  output vad_pkg::vad_dec_s dec_out
);
  import vad_pkg::*;

  // ==========================================================
  // Bus slave
  logic ap_write;
  logic [VAD_AW-1:0] ap_addr;
  logic bus_take;
  logic [1:0] ctrl_sew;
  logic [2:0] ctrl_frm;
  logic ctrl_fint;
  logic ctrl_en;
  logic [15:0] dec_count;
  logic [15:0] ill_count;
  logic [31:0] last_instr;
  logic ctrl_wr;
  logic [31:0] ctrl_word;
  logic [31:0] next_rdata;

  assign bus_take = hsel && hready && htrans[1];
  assign ctrl_wr = ap_write && (ap_addr == VAD_CTRL_OFS);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ap_write <= 1'b0;
      ap_addr <= '0;
    end else if (hready) begin
      ap_write <= bus_take && hwrite;
      ap_addr <= haddr[VAD_AW-1:0];
    end
  end

  // Zero wait states: held not ready in reset, then always ready and OKAY from the first clock after
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_sew <= VAD_CTRL_SEW_RST;
      ctrl_frm <= VAD_CTRL_FRM_RST;
      ctrl_fint <= 1'b0;
      ctrl_en <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_sew <= hwdata[VAD_CTRL_SEW_LO+:2];
      ctrl_frm <= hwdata[VAD_CTRL_FRM_LO+:3];
      ctrl_fint <= hwdata[VAD_CTRL_FINT_BIT];
      ctrl_en <= hwdata[VAD_CTRL_EN_BIT];
    end
  end

  // A read in the data phase of a control write sees the new value
  always_comb begin
    ctrl_word = '0;
    if (ctrl_wr) begin
      ctrl_word[VAD_CTRL_EN_BIT:0] = hwdata[VAD_CTRL_EN_BIT:0];
    end else begin
      ctrl_word[VAD_CTRL_SEW_LO+:2] = ctrl_sew;
      ctrl_word[VAD_CTRL_FRM_LO+:3] = ctrl_frm;
      ctrl_word[VAD_CTRL_FINT_BIT] = ctrl_fint;
      ctrl_word[VAD_CTRL_EN_BIT] = ctrl_en;
    end
  end

  always_comb begin
    case (haddr[VAD_AW-1:0])
      VAD_CTRL_OFS: next_rdata = ctrl_word;
      VAD_STAT_OFS: next_rdata = {ill_count, dec_count};
      VAD_LAST_OFS: next_rdata = last_instr;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= '0;
    end else if (bus_take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ==========================================================
  // Field extraction
  logic is_vec;
  logic [5:0] op_sel;
  vad_cat_e cat;
  vad_sew_e selected_element_width;
  logic [7:0] sew_bits;
  logic is_float;
  logic fp_width_ok;
  logic frm_ok;
  logic reserved;
  vad_src_e scal_src;
  logic read_src1_vec;
  logic [VAD_ELEN-1:0] scalar_val;

  assign is_vec = issue_valid && (issue_instr[6:0] == VAD_MAJOR_OPCODE); // [RULE1]
  assign op_sel = issue_instr[VAD_OPSEL_HI:VAD_OPSEL_LO]; // [RULE2]
  assign cat = vad_cat_e'(issue_instr[VAD_CAT_HI:VAD_CAT_LO]); // [RULE3]
  assign selected_element_width = vad_sew_e'(ctrl_sew);
  assign sew_bits = 8'(8) << ctrl_sew;
  assign is_float = (cat == VAD_FLOAT_VEC_VEC_CATEGORY) ||
                    (cat == VAD_FLOAT_VEC_SCALAR_CATEGORY);

  // Float register too narrow only matters when floats live in f registers
  assign fp_width_ok = FP_SEW_MASK[ctrl_sew] &&
                       (ctrl_fint || (32'(FLOAT_REGISTER_WIDTH) >= 32'(sew_bits))); // [RULE11]
  // Checked for every float op regardless of length or start index
  assign frm_ok = (ctrl_frm <= VAD_FRM_MAX_VALID); // [RULE16] [RULE17]
  assign reserved = !ctrl_en || (is_float && (!fp_width_ok || !frm_ok)); // [RULE11]

  // ==========================================================
  // Operand source selection
  always_comb begin
    case (cat)
      VAD_INT_VEC_IMM_CATEGORY: scal_src = VAD_SRC_IMM; // [RULE6]
      VAD_INT_VEC_SCALAR_CATEGORY,
      VAD_MASKMUL_VEC_SCALAR_CATEGORY: scal_src = VAD_SRC_XREG; // [RULE6]
      VAD_FLOAT_VEC_SCALAR_CATEGORY: begin
        scal_src = ctrl_fint ? VAD_SRC_XREG : VAD_SRC_FREG; // [RULE12]
      end
      VAD_VECTOR_CONFIG_CATEGORY: scal_src = VAD_SRC_XREG; // [RULE4]
      default: scal_src = VAD_SRC_NONE;
    endcase
  end

  assign read_src1_vec = (cat == VAD_INT_VEC_VEC_CATEGORY) ||
                         (cat == VAD_FLOAT_VEC_VEC_CATEGORY) ||
                         (cat == VAD_MASKMUL_VEC_VEC_CATEGORY); // [RULE5]

  vad_scalar_fmt #(
    .INTEGER_REGISTER_WIDTH(INTEGER_REGISTER_WIDTH),
    .FLOAT_REGISTER_WIDTH(FLOAT_REGISTER_WIDTH)
  ) u_fmt (
    .selected_element_width(selected_element_width),
    .src(scal_src),
    .uimm(UIMM_OPS[op_sel]),
    .imm(issue_instr[VAD_SRC1_HI:VAD_SRC1_LO]),
    .xreg(xreg_data),
    .freg(freg_data),
    .operand(scalar_val)
  );

  // ==========================================================
  // Decoded output register, one cycle after issue
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dec_out <= '0;
    end else begin
      dec_out.valid <= is_vec;
      dec_out.illegal <= is_vec && reserved; // [RULE18]
      dec_out.dest_we <= is_vec && !reserved; // [RULE18]
      dec_out.operation_select_field <= op_sel; // [RULE2]
      dec_out.mask_enable_bit <= issue_instr[VAD_MASK_BIT]; // [RULE13]
      dec_out.second_vector_source <= issue_instr[VAD_SRC2_HI:VAD_SRC2_LO]; // [RULE2]
      dec_out.first_vector_source <= issue_instr[VAD_SRC1_HI:VAD_SRC1_LO]; // [RULE2]
      dec_out.vector_destination <= issue_instr[VAD_DEST_HI:VAD_DEST_LO]; // [RULE2]
      dec_out.category <= cat; // [RULE3]
      dec_out.read_src2_vec <= (cat != VAD_VECTOR_CONFIG_CATEGORY); // [RULE5] [RULE6]
      dec_out.read_src1_vec <= read_src1_vec; // [RULE5]
      dec_out.scalar_src <= scal_src;
      dec_out.op_signed <= !is_float && SIGNED_OPS[op_sel]; // [RULE14]
      dec_out.round_mode <= ctrl_frm; // [RULE15]
      dec_out.cfg_second_reg <= (cat == VAD_VECTOR_CONFIG_CATEGORY) &&
        (issue_instr[VAD_CFG_SEL_HI:VAD_CFG_SEL_LO] == 2'h2); // [RULE4]
      dec_out.cfg_imm <= issue_instr[VAD_CFG_IMM_HI:VAD_CFG_IMM_LO]; // [RULE4]
      dec_out.scalar_operand <= scalar_val;
    end
  end

  // ==========================================================
  // Statistics; counters wrap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dec_count <= '0;
      ill_count <= '0;
      last_instr <= '0;
    end else if (is_vec) begin
      dec_count <= dec_count + 16'h1;
      last_instr <= issue_instr;
      if (reserved) begin
        ill_count <= ill_count + 16'h1;
      end
    end
  end

endmodule : vad_decode
`default_nettype wire

// [test/vad_issue_model.sv]
`default_nettype none
module vad_issue_model #(
  parameter int INTEGER_REGISTER_WIDTH = 32,
  parameter int FLOAT_REGISTER_WIDTH = 32
) (
  // Issue stream
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  // Register read data
  output logic [INTEGER_REGISTER_WIDTH-1:0] xreg_data,
  output logic [FLOAT_REGISTER_WIDTH-1:0] freg_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [INTEGER_REGISTER_WIDTH-1:0] xr [32];
  logic [FLOAT_REGISTER_WIDTH-1:0] fr [32];
  // Outside an issue the read ports flip, so stale data never passes for a fresh read
  always_comb begin
    xreg_data = xr[issue_instr[19:15]];
    freg_data = fr[issue_instr[19:15]];
    if (!issue_valid) begin
      xreg_data = ~xreg_data;
      freg_data = ~freg_data;
    end
  end
endmodule : vad_issue_model
`default_nettype wire

// [test/vad_decode_checker.sv]
`default_nettype none
module vad_decode_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Issue and decode
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire vad_pkg::vad_dec_s dec_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import vad_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take;
  logic ok;
  assign take = issue_valid && issue_instr[6:0] == VAD_MAJOR_OPCODE;
  assign ok = dec_out.valid && !dec_out.illegal;
  chk_opcode_take: assert property (take |=> dec_out.valid)
    else $error("vector word not decoded");
  chk_other_drop: assert property (!take |=> !dec_out.valid)
    else $error("other word decoded");
  chk_field_split: assert property (take |=> {dec_out.operation_select_field,
    dec_out.second_vector_source, dec_out.first_vector_source, dec_out.vector_destination}
    == $past({issue_instr[31:26], issue_instr[24:15], issue_instr[11:7]}))
    else $error("field split wrong");
  chk_mask_follow: assert property (take |=> dec_out.mask_enable_bit == $past(issue_instr[25]))
    else $error("mask bit wrong");
  chk_cat_follow: assert property (take |=> dec_out.category == $past(issue_instr[14:12]))
    else $error("category wrong");
  chk_vv_reads: assert property (ok && dec_out.category <= VAD_MASKMUL_VEC_VEC_CATEGORY
    |-> dec_out.read_src1_vec && dec_out.read_src2_vec)
    else $error("vector sources not read");
  chk_vs_source: assert property (ok && dec_out.category inside {[3:6]}
    |-> dec_out.read_src2_vec && !dec_out.read_src1_vec && dec_out.scalar_src != VAD_SRC_NONE)
    else $error("scalar form sources wrong");
  chk_imm_source: assert property (ok && dec_out.category == VAD_INT_VEC_IMM_CATEGORY
    |-> dec_out.scalar_src == VAD_SRC_IMM)
    else $error("immediate not selected");
  chk_write_block: assert property (dec_out.dest_we == ok)
    else $error("write enable wrong");
  cover property (dec_out.valid && dec_out.illegal);
  cover property (ok && dec_out.category == VAD_INT_VEC_IMM_CATEGORY);
  cover property (ok && dec_out.category == VAD_VECTOR_CONFIG_CATEGORY);
endmodule : vad_decode_checker
bind vad_decode vad_decode_checker vad_decode_checker_i (.clk(clk), .resetn(resetn),
  .issue_valid(issue_valid), .issue_instr(issue_instr), .dec_out(dec_out));
`default_nettype wire

// [test/tb_vector_arith_decode.sv]
`default_nettype none
module tb_vector_arith_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import vad_pkg::*;
  localparam logic [63:0] SOPS = 64'h0000_0000_0000_0003;
  localparam logic [63:0] UOPS = 64'h0000_0000_0000_0020;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, issue_valid, fint, en;
  logic [31:0] haddr, hwdata, hrdata, issue_instr, rd, xreg_data, freg_data, last, stim;
  logic [1:0] htrans, selected_element_width;
  logic [2:0] hsize, frm;
  vad_dec_s dec_out;
  int failures, n_checks, n_vec, n_bad;
  vad_decode #(.INTEGER_REGISTER_WIDTH(32), .FLOAT_REGISTER_WIDTH(32), .UIMM_OPS(UOPS), .SIGNED_OPS(SOPS)) vad_decode_i (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .xreg_data(xreg_data), .freg_data(freg_data),
    .dec_out(dec_out));
  vad_issue_model #(.INTEGER_REGISTER_WIDTH(32), .FLOAT_REGISTER_WIDTH(32)) vad_issue_model_i (.issue_valid(issue_valid),
    .issue_instr(issue_instr), .xreg_data(xreg_data), .freg_data(freg_data));
  // ==========================================================
  // Checking and verdict
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  function automatic logic [63:0] exp_op(input logic [31:0] ins, x, f);
    logic [63:0] m, v;
    m = (64'h1 << (8 << selected_element_width)) - 64'h1;
    v = {{32{x[31]}}, x};
    if (ins[14:12] == 3'h3)
      v = UOPS[ins[31:26]] ? {59'h0, ins[19:15]} : {{59{ins[19]}}, ins[19:15]};
    // Narrow float scalars must carry all ones above the element
    if (ins[14:12] == 3'h5 && !fint)
      v = (({32'h0, f} | m) & 64'hffff_ffff) != 64'hffff_ffff ?
        (selected_element_width == 2'h1 ? VAD_NAN_H : VAD_NAN_S) : {32'h0, f};
    return v & m;
  endfunction : exp_op
  // ==========================================================
  // Bus and issue drivers
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic setc(input logic [1:0] s, input logic [2:0] f, input logic i);
    // Float-in-integer mode stays within the integer width
    selected_element_width = (i && s == 2'h3) ? 2'h2 : s;
    frm = f;
    fint = i;
    en = 1'b1;
    bus(1'b1, VAD_CTRL_OFS, {25'h0, en, fint, frm, selected_element_width});
  endtask : setc
  task automatic issue(input logic [31:0] ins);
    logic [2:0] c;
    logic ill;
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_instr <= ins;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    chk(64'(dec_out.valid), 64'(ins[6:0] == VAD_MAJOR_OPCODE), "valid");
    if (ins[6:0] == VAD_MAJOR_OPCODE) begin
      c = ins[14:12];
      ill = !en || ((c == 3'h1 || c == 3'h5) && (frm > 3'h4 || selected_element_width == 2'h0 || selected_element_width == 2'h3));
      n_vec++;
      n_bad += 32'(ill);
      last = ins;
      chk(64'(dec_out.illegal), 64'(ill), "illegal");
      chk(64'(dec_out.dest_we), 64'(!ill), "dest_we");
      chk(64'({dec_out.operation_select_field, dec_out.mask_enable_bit}), 64'(ins[31:25]),
        "select");
      chk(64'(dec_out.category), 64'(c), "category");
      chk(64'(dec_out.op_signed), 64'(c != 3'h1 && c != 3'h5 && SOPS[ins[31:26]]), "signed");
      if (!ill && (c == 3'h1 || c == 3'h5)) chk(64'(dec_out.round_mode), 64'(frm), "frm");
      if (c == 3'h7) chk(64'(dec_out.cfg_second_reg), 64'(ins[31:30] == 2'h2), "cfg");
      if (c == 3'h7 && ins[31:30] != 2'h2) chk(64'(dec_out.cfg_imm), 64'(ins[30:20]), "imm");
      if (!ill && c > 3'h2 && c < 3'h7) chk(dec_out.scalar_operand, exp_op(ins,
        vad_issue_model_i.xr[ins[19:15]], vad_issue_model_i.fr[ins[19:15]]),
        "operand");
    end
  endtask : issue
  // ==========================================================
  // Clock, watchdog and tests
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    {resetn, hsel, hwrite, issue_valid, fint, en, htrans, selected_element_width, frm} = '0;
    {haddr, hwdata, issue_instr, last} = '0;
    hsize = 3'h2;
    {failures, n_checks, n_vec, n_bad} = '0;
    void'($urandom(93726));
    for (int i = 0; i < 32; i++) begin
      vad_issue_model_i.xr[i] = $urandom;
      vad_issue_model_i.fr[i] = i[0] ? {16'hffff, 16'($urandom)} : $urandom;
    end
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, VAD_CTRL_OFS, 32'h0);
    chk(64'(rd), 64'h0, "ctrl");
    issue(32'h0000_3057);
    // Every width, rounding mode and scalar source mode on float scalars
    for (int i = 0; i < 64; i++) begin
      setc(i[1:0], i[4:2], i[5]);
      issue({6'h0, i[0], 5'h3, 5'(i), 3'h5, 5'h1, VAD_MAJOR_OPCODE});
    end
    for (int k = 0; k < 300; k++) begin
      if (k % 16 == 0) setc(2'($urandom), 3'($urandom % 5), 1'($urandom));
      stim = $urandom;
      if (k % 8 == 1) stim[31:26] = 6'h5;
      if (k % 4 != 0) stim[6:0] = VAD_MAJOR_OPCODE;
      issue(stim);
    end
    bus(1'b0, VAD_STAT_OFS, 32'h0);
    chk(64'(rd), 64'({n_bad[15:0], n_vec[15:0]}), "stat");
    bus(1'b0, VAD_LAST_OFS, 32'h0);
    chk(64'(rd), 64'(last), "last");
    bus(1'b0, 8'h0c, 32'h0);
    chk(64'(rd), 64'h0, "unmapped");
    results();
  end
endmodule : tb_vector_arith_decode
`default_nettype wire
